// ==== jl_pkg.sv ====
/*
  jl_pkg: constants, encodings and link parameters shared by the
  transmit link layer and its 8b/10b encoder.
  Assumes one octet per lane per clock at the core clock rate.
*/
package jl_pkg;
  // core clock
  localparam int CLK_MHZ = 40;
  localparam int LANES = 3;

  // control characters (K28.y) and the D21.5 pattern as octets, then the 10-bit reset symbol
  localparam logic [7:0] K_R = 8'h1C;
  localparam logic [7:0] K_A = 8'h7C;
  localparam logic [7:0] K_Q = 8'h9C;
  localparam logic [7:0] K_K = 8'hBC;
  localparam logic [7:0] K_F = 8'hFC;
  localparam logic [7:0] D21_5 = 8'hB5;
  localparam logic [9:0] SYM_RESET = 10'h0FA;

  // alignment sequence layout
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  localparam logic [1:0] CFG_MF = 2'h1;
  localparam logic [7:0] CFG_FIRST = 8'h02;
  localparam logic [7:0] CFG_LEN = 8'h0E;

  // encoded link parameters (value minus one where the field is so encoded)
  localparam logic [2:0] F_EFF_M1 = 3'h6;
  localparam logic [2:0] F_SIM_M1 = 3'h1;
  localparam logic [7:0] L3_M1 = 8'h02;
  localparam logic [7:0] L2_M1 = 8'h01;
  localparam logic [7:0] M_M1 = 8'h01;
  localparam logic [7:0] N_M1 = 8'h0D;
  localparam logic [7:0] NP_EFF_M1 = 8'h0D;
  localparam logic [7:0] NP_SIM_M1 = 8'h0F;
  localparam logic [7:0] S_EFF3_M1 = 8'h05;
  localparam logic [7:0] S_EFF2_M1 = 8'h03;
  localparam logic [7:0] S_SIM_M1 = 8'h00;
  localparam logic [7:0] SUBCLASS = 8'h02;
  localparam logic [7:0] JESDV = 8'h01;
  localparam int SCR_POS = 7;
  localparam int SUBCLASS_POS = 5;
  localparam int JESDV_POS = 5;

  // lane rate multipliers over sample rate, as numerator / denominator
  localparam int RATE_EFF3_NUM = 280;
  localparam int RATE_EFF3_DEN = 24;
  localparam int RATE_EFF2_NUM = 280;
  localparam int RATE_EFF2_DEN = 16;
  localparam int RATE_SIM_NUM = 320;
  localparam int RATE_SIM_DEN = 16;

  // transport packing
  localparam logic [4:0] W_EFF = 5'h0E;
  localparam logic [4:0] W_SIM = 5'h10;
  localparam logic [4:0] OCT_BITS = 5'h08;
  localparam logic [1:0] TAIL_BITS = 2'h0;

  // test pattern control register
  localparam logic [7:0] ADDR_TP_CTRL = 8'hC0;
  localparam logic [7:0] TP_CTRL_RESET = 8'h00;
  localparam int TP_EN_BIT = 0;
  localparam int TP_SEL_LSB = 1;
  localparam int TP_SEL_MSB = 3;
  localparam logic [13:0] CHK_A = 14'h2AAA;
  localparam logic [13:0] CHK_B = 14'h1555;
  localparam logic [6:0] PRBS_SEED = 7'h7F;

  typedef enum logic [2:0] {
    TP_OFF = 3'b000,
    TP_RAMP = 3'b001,
    TP_CHECK = 3'b010,
    TP_PRBS7 = 3'b011,
    TP_D215 = 3'b100,
    TP_K285 = 3'b101
  } jl_tp_t;

  typedef enum logic [1:0] {
    ST_CGS = 2'b00,
    ST_ILA = 2'b01,
    ST_DATA = 2'b10
  } jl_state_t;
endpackage

// ==== jl_sym_if.sv ====
/*
  jl_sym_if: octet and control flag into one lane encoder, symbol back.
  Assumes the source holds octet and flag in flip-flops.
*/
`timescale 1ns/10ps
interface jl_sym_if;
  logic [7:0] octet;
  logic isK;
  logic [9:0] symbol;
  modport src(output octet, output isK, input symbol);
  modport enc(input octet, input isK, output symbol);
endinterface

// ==== jl_enc8b10b.sv ====
/*
  jl_enc8b10b: one lane of 8b/10b encoding with running disparity.
  Assumes control octets are only K28.y; symbol bit 9 leaves the lane first.
*/
`timescale 1ns/10ps
module jl_enc8b10b
  import jl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // octet in, symbol out
  jl_sym_if.enc sym
);
  typedef struct packed {
    logic rd;
    logic [9:0] symbol;
  } jl_enc_state_t;

  jl_enc_state_t q;
  jl_enc_state_t n;

  function automatic logic [5:0] code6(input logic [4:0] x);
    case (x)
      5'h00: code6 = 6'b100111;
      5'h01: code6 = 6'b011101;
      5'h02: code6 = 6'b101101;
      5'h03: code6 = 6'b110001;
      5'h04: code6 = 6'b110101;
      5'h05: code6 = 6'b101001;
      5'h06: code6 = 6'b011001;
      5'h07: code6 = 6'b111000;
      5'h08: code6 = 6'b111001;
      5'h09: code6 = 6'b100101;
      5'h0A: code6 = 6'b010101;
      5'h0B: code6 = 6'b110100;
      5'h0C: code6 = 6'b001101;
      5'h0D: code6 = 6'b101100;
      5'h0E: code6 = 6'b011100;
      5'h0F: code6 = 6'b010111;
      5'h10: code6 = 6'b011011;
      5'h11: code6 = 6'b100011;
      5'h12: code6 = 6'b010011;
      5'h13: code6 = 6'b110010;
      5'h14: code6 = 6'b001011;
      5'h15: code6 = 6'b101010;
      5'h16: code6 = 6'b011010;
      5'h17: code6 = 6'b111010;
      5'h18: code6 = 6'b110011;
      5'h19: code6 = 6'b100110;
      5'h1A: code6 = 6'b010110;
      5'h1B: code6 = 6'b110110;
      5'h1C: code6 = 6'b001110;
      5'h1D: code6 = 6'b101110;
      5'h1E: code6 = 6'b011110;
      default: code6 = 6'b101011;
    endcase
  endfunction

  function automatic logic [9:0] codeK28(input logic [2:0] y);
    case (y)
      3'h0: codeK28 = 10'b0011110100;
      3'h1: codeK28 = 10'b0011111001;
      3'h2: codeK28 = 10'b0011110101;
      3'h3: codeK28 = 10'b0011110011;
      3'h4: codeK28 = 10'b0011110010;
      3'h5: codeK28 = 10'b0011111010;
      3'h6: codeK28 = 10'b0011110110;
      default: codeK28 = 10'b0011111000;
    endcase
  endfunction

  always_comb begin
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] c10;
    logic rd1;
    c6 = code6(sym.octet[4:0]);
    c4 = 4'h0;
    c10 = codeK28(sym.octet[7:5]);
    rd1 = q.rd;
    n = q;
    // disparity is tracked across every octet, commas included
    if (sym.isK) begin
      if (q.rd) begin
        c10 = ~c10;
      end
      n.rd = q.rd ^ ($countones(c10) != 5);
      n.symbol = c10;
    end else begin
      if (q.rd && (($countones(c6) != 3) || (c6 == 6'b111000))) begin
        c6 = ~c6;
      end
      rd1 = q.rd ^ ($countones(c6) != 3);
      case (sym.octet[7:5])
        3'h0: c4 = 4'b1011;
        3'h1: c4 = 4'b1001;
        3'h2: c4 = 4'b0101;
        3'h3: c4 = 4'b1100;
        3'h4: c4 = 4'b1101;
        3'h5: c4 = 4'b1010;
        3'h6: c4 = 4'b0110;
        default: c4 = 4'b1110;
      endcase
      // alternate x.7 avoids a run of five equal bits across the boundary
      if ((sym.octet[7:5] == 3'h7) &&
          ((!rd1 && c6[1] && c6[0]) || (rd1 && !c6[1] && !c6[0]))) begin
        c4 = 4'b0111;
      end
      if (rd1 && (($countones(c4) != 2) || (c4 == 4'b1100))) begin
        c4 = ~c4;
      end
      n.rd = rd1 ^ ($countones(c4) != 2);
      n.symbol = {c6, c4};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // the reset symbol is K28.5 RD-, which leaves the running disparity positive
      q <= '{rd: 1'b1, symbol: SYM_RESET};
    end else begin
      q <= n;
    end
  end

  assign sym.symbol = q.symbol;
endmodule

// ==== jl_tx_link.sv ====
/*
  jl_tx_link: transmit link layer of a three-lane serial converter link:
  code group sync, alignment sequence, packing, scrambling, octet
  substitution, test patterns and 8b/10b encoding per lane.
  Assumes syncN and all inputs are synchronous to clk, samples arrive
  already mapped to lanes, and link parameters are held steady by software.
*/
`timescale 1ns/10ps
module jl_tx_link
  import jl_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h00,  // arbitrary value
  parameter logic [7:0] BANK_ID = 8'h00  // arbitrary value
)(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sync pin, active low
  input wire logic syncN,
  // link configuration
  input wire logic cfgSimple,
  input wire logic cfgTwoLane,
  input wire logic [4:0] cfgKMinus1,
  input wire logic cfgScrambleEn,
  input wire logic cfgLaneSyncEn,
  input wire logic cfgSyncIsDivReset,
  // register port
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgWrEn,
  output logic [7:0] cfgRdData,
  // samples per lane
  input wire logic [LANES-1:0][13:0] laneSample,
  output logic [LANES-1:0] sampleTake,
  // lane symbols and status
  output logic [LANES-1:0][9:0] laneSymbol,
  output logic [1:0] linkState,
  output logic clkDivReset
);
  typedef struct packed {
    jl_state_t state;
    logic syncPrev;
    logic pinLowPrev;
    logic divRst;
    logic simple;
    logic twoLane;
    logic [4:0] kMinus1;
    logic scrEn;
    logic laneSyncEn;
    logic [2:0] octCnt;
    logic [4:0] frmCnt;
    logic [1:0] mfCnt;
    logic [7:0] mfPos;
    logic [7:0] tpCtrl;
    logic [7:0] rdData;
    logic [13:0] tpRamp;
    logic tpPhase;
    logic [6:0] prbs;
    logic [LANES-1:0] take;
    logic [LANES-1:0][23:0] acc;
    logic [LANES-1:0][4:0] fill;
    logic [LANES-1:0][14:0] scr;
    logic [LANES-1:0][7:0] lastOct;
    logic [LANES-1:0] lastVld;
    logic [LANES-1:0][7:0] octet;
    logic [LANES-1:0] isK;
  } jl_tx_state_t;

  jl_tx_state_t q;
  jl_tx_state_t n;

  // commas leave the lanes from the first edge after reset
  localparam jl_tx_state_t Q_RESET = '{state: ST_CGS, octet: {LANES{K_K}}, isK: '1,
                                       default: '0};

  // one configuration octet of the second alignment multiframe
  function automatic logic [7:0] cfgOctet(input logic [7:0] idx, input logic [7:0] lane,
                                          input logic simple, input logic twoLane,
                                          input logic scr, input logic [4:0] kM1);
    logic [7:0] lM1;
    logic [7:0] fM1;
    logic [7:0] sM1;
    logic [7:0] npM1;
    logic [7:0] chk;
    lM1 = twoLane ? L2_M1 : L3_M1;
    fM1 = {5'h00, simple ? F_SIM_M1 : F_EFF_M1};
    sM1 = simple ? S_SIM_M1 : (twoLane ? S_EFF2_M1 : S_EFF3_M1);
    npM1 = simple ? NP_SIM_M1 : NP_EFF_M1;
    chk = DEV_ID + BANK_ID + lane + {7'h00, scr} + lM1 + fM1 + {3'h0, kM1} + M_M1 + N_M1 +
          npM1 + SUBCLASS + sM1 + JESDV;
    case (idx)
      8'h00: cfgOctet = DEV_ID;
      8'h01: cfgOctet = BANK_ID;
      8'h02: cfgOctet = lane;
      8'h03: cfgOctet = ({7'h00, scr} << SCR_POS) | lM1;
      8'h04: cfgOctet = fM1;
      8'h05: cfgOctet = {3'h0, kM1};
      8'h06: cfgOctet = M_M1;
      8'h07: cfgOctet = N_M1;
      8'h08: cfgOctet = (SUBCLASS << SUBCLASS_POS) | npM1;
      8'h09: cfgOctet = (JESDV << JESDV_POS) | sM1;
      8'h0D: cfgOctet = chk;
      default: cfgOctet = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic syncReq;
    logic release_;
    logic frameEnd;
    logic mfEnd;
    logic tpEn;
    jl_tp_t tpSel;
    logic [2:0] fM1;
    logic [23:0] a;
    logic [4:0] fl;
    logic [13:0] word;
    logic [7:0] d;
    logic [7:0] o;
    logic [14:0] s;
    logic [6:0] p;
    logic [7:0] prbsOct;
    syncReq = 1'b0;
    release_ = 1'b0;
    frameEnd = 1'b0;
    mfEnd = 1'b0;
    tpEn = 1'b0;
    tpSel = TP_OFF;
    fM1 = F_EFF_M1;
    a = '0;
    fl = '0;
    word = '0;
    d = '0;
    o = '0;
    s = '0;
    p = q.prbs;
    prbsOct = '0;
    n = q;

    // the pin is the link sync unless steered to the divider reset
    syncReq = ~syncN & ~cfgSyncIsDivReset;
    release_ = q.syncPrev & ~syncReq;
    n.syncPrev = syncReq;
    n.pinLowPrev = ~syncN;
    n.divRst = cfgSyncIsDivReset & ~syncN & ~q.pinLowPrev;

    // register port: write takes effect next cycle, read data is registered
    if (cfgWrEn && (cfgAddr == ADDR_TP_CTRL)) begin
      n.tpCtrl = cfgWrData;
    end
    n.rdData = (cfgAddr == ADDR_TP_CTRL) ? q.tpCtrl : 8'h00;
    tpEn = q.tpCtrl[TP_EN_BIT];
    tpSel = jl_tp_t'(q.tpCtrl[TP_SEL_MSB:TP_SEL_LSB]);

    // frame length follows packing: 7 octets efficient, 2 simple
    fM1 = q.simple ? F_SIM_M1 : F_EFF_M1;
    frameEnd = (q.octCnt == fM1);
    mfEnd = frameEnd && (q.frmCnt == q.kMinus1);

    // eight PRBS7 bits per octet, x^7 + x^6 + 1
    for (int i = 7; i >= 0; i--) begin
      p = {p[5:0], p[6] ^ p[5]};
      prbsOct[i] = p[0];
    end

    for (int l = 0; l < LANES; l++) begin
      n.octet[l] = K_K;
      n.isK[l] = 1'b1;
      s = q.scr[l];
      case (q.state)
        ST_CGS: begin
          n.octet[l] = K_K;
          n.isK[l] = 1'b1;
        end
        ST_ILA: begin
          // markers: start of each multiframe, its end, config start
          if (q.mfPos == 8'h00) begin
            n.octet[l] = K_R;
          end else if (mfEnd) begin
            n.octet[l] = K_A;
          end else if ((q.mfCnt == CFG_MF) && (q.mfPos == 8'h01)) begin
            n.octet[l] = K_Q;
          end else if ((q.mfCnt == CFG_MF) && (q.mfPos >= CFG_FIRST) &&
                       (q.mfPos < CFG_FIRST + CFG_LEN)) begin
            n.octet[l] = cfgOctet(q.mfPos - CFG_FIRST, 8'(l), q.simple, q.twoLane,
                                  q.scrEn, q.kMinus1);
            n.isK[l] = 1'b0;
          end else begin
            n.octet[l] = q.mfPos;
            n.isK[l] = 1'b0;
          end
          // the sequence shifts through the scrambler register as sent
          if (q.scrEn) begin
            for (int i = 7; i >= 0; i--) begin
              s = {s[13:0], n.octet[l][i]};
            end
          end
        end
        ST_DATA: begin
          a = q.acc[l];
          fl = q.fill[l];
          // test words take the sample path, so they are packed alike
          if (tpEn && (tpSel == TP_RAMP)) begin
            word = q.tpRamp;
          end else if (tpEn && (tpSel == TP_CHECK)) begin
            word = q.tpPhase ? CHK_B : CHK_A;
          end else begin
            word = laneSample[l];
          end
          if (q.take[l]) begin
            if (q.simple) begin
              a = a | ({word, TAIL_BITS, 8'h00} >> fl);
              fl = fl + W_SIM;
            end else begin
              a = a | ({word, 10'h000} >> fl);
              fl = fl + W_EFF;
            end
          end
          d = a[23:16];
          n.acc[l] = a << OCT_BITS;
          n.fill[l] = fl - OCT_BITS;
          o = d;
          if (q.scrEn) begin
            for (int i = 7; i >= 0; i--) begin
              o[i] = d[i] ^ s[14] ^ s[13];
              s = {s[13:0], o[i]};
            end
          end
          n.octet[l] = o;
          n.isK[l] = 1'b0;
          if (frameEnd) begin
            if (q.lastVld[l] && (o == q.lastOct[l])) begin
              n.isK[l] = 1'b1;
              if (mfEnd && q.laneSyncEn) begin
                n.octet[l] = K_A;
              end else begin
                n.octet[l] = K_F;
              end
            end
            n.lastOct[l] = o;
            n.lastVld[l] = 1'b1;
          end
          // link patterns bypass packing and scrambling
          if (tpEn && (tpSel == TP_PRBS7)) begin
            n.octet[l] = prbsOct;
            n.isK[l] = 1'b0;
          end else if (tpEn && (tpSel == TP_D215)) begin
            n.octet[l] = D21_5;
            n.isK[l] = 1'b0;
          end else if (tpEn && (tpSel == TP_K285)) begin
            n.octet[l] = K_K;
            n.isK[l] = 1'b1;
          end
        end
        default: begin
          n.octet[l] = K_K;
          n.isK[l] = 1'b1;
        end
      endcase
      n.scr[l] = s;
      // an unused third lane keeps idling on commas
      if (q.twoLane && (l == LANES - 1)) begin
        n.octet[l] = K_K;
        n.isK[l] = 1'b1;
      end
    end

    if (q.state == ST_DATA) begin
      n.prbs = p;
      if (q.take[0]) begin
        n.tpRamp = q.tpRamp + 14'h0001;
        n.tpPhase = ~q.tpPhase;
      end
    end

    if (syncReq) begin
      // hold in comma mode; configuration is taken only here
      n.state = ST_CGS;
      n.simple = cfgSimple;
      n.twoLane = cfgTwoLane;
      n.kMinus1 = cfgKMinus1;
      n.scrEn = cfgScrambleEn;
      n.laneSyncEn = cfgLaneSyncEn;
      n.octCnt = '0;
      n.frmCnt = '0;
      n.mfCnt = '0;
      n.mfPos = '0;
    end else if ((q.state == ST_CGS) && release_) begin
      // release is the common time origin: all counters and patterns restart
      n.state = ST_ILA;
      n.octCnt = '0;
      n.frmCnt = '0;
      n.mfCnt = '0;
      n.mfPos = '0;
      n.tpRamp = '0;
      n.tpPhase = 1'b0;
      n.prbs = PRBS_SEED;
      n.acc = '0;
      n.fill = '0;
      n.scr = '0;
      n.lastVld = '0;
    end else if (q.state != ST_CGS) begin
      n.octCnt = frameEnd ? 3'h0 : q.octCnt + 3'h1;
      n.mfPos = mfEnd ? 8'h00 : q.mfPos + 8'h01;
      if (frameEnd) begin
        n.frmCnt = mfEnd ? 5'h00 : q.frmCnt + 5'h01;
      end
      if (mfEnd) begin
        n.mfCnt = q.mfCnt + 2'h1;
        if ((q.state == ST_ILA) && (q.mfCnt == ILA_LAST_MF)) begin
          n.state = ST_DATA;
        end
      end
    end

    for (int l = 0; l < LANES; l++) begin
      n.take[l] = (n.state == ST_DATA) && (n.fill[l] < OCT_BITS);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= Q_RESET;
    end else begin
      q <= n;
    end
  end

  // one encoder per lane, fed from registered octets
  for (genvar gl = 0; gl < LANES; gl++) begin : g_lane
    jl_sym_if symIf();
    assign symIf.octet = q.octet[gl];
    assign symIf.isK = q.isK[gl];
    jl_enc8b10b u_enc (
      .clk(clk),
      .reset(reset),
      .sym(symIf)
    );
    assign laneSymbol[gl] = symIf.symbol;
  end

  assign cfgRdData = q.rdData;
  assign sampleTake = q.take;
  assign linkState = q.state;
  assign clkDivReset = q.divRst;
endmodule

// ==== jl_tx_link_assertions.sv ====
/*
  jl_tx_link_chk: concurrent checks on the link layer top ports.
  Assumes one clk domain, active high asynchronous reset; bound in below.
*/
`timescale 1ns/10ps
module jl_tx_link_chk
  import jl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sync pin and configuration
  input wire logic syncN,
  input wire logic cfgSimple,
  input wire logic [4:0] cfgKMinus1,
  input wire logic cfgSyncIsDivReset,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgWrEn,
  // outputs
  input wire logic [7:0] cfgRdData,
  input wire logic [LANES-1:0] sampleTake,
  input wire logic [LANES-1:0][9:0] laneSymbol,
  input wire logic [1:0] linkState,
  input wire logic clkDivReset
);
  // K28.y at negative disparity; the positive form is the bitwise inverse
  localparam logic [9:0] S_K0 = 10'h0F4;
  localparam logic [9:0] S_K3 = 10'h0F3;
  localparam logic [9:0] S_K5 = 10'h0FA;
  logic [11:0] lenQ;
  logic [11:0] cntQ;
  logic [9:0] sym0;
  assign sym0 = laneSymbol[0];
  // length is latched whenever syncN is low, even when the pin is steered to the divider reset; the link parameters only on a sync request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lenQ <= 12'h000;
      cntQ <= 12'h000;
    end else begin
      if (!syncN) begin
        lenQ <= 12'(4 * (cfgKMinus1 + 1) * (cfgSimple ? 2 : 7));
      end
      cntQ <= (linkState == 2'h1) ? cntQ + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_comma;
    !syncN && !cfgSyncIsDivReset |=> linkState == 2'h0;
  endproperty
  a_comma: assert property (p_comma) else $error("no comma state on sync request");
  property p_commaAlt;
    linkState == 2'h0 [*4] |-> (sym0 == S_K5 || sym0 == ~S_K5) && sym0 == ~$past(sym0);
  endproperty
  a_commaAlt: assert property (p_commaAlt) else $error("comma disparity wrong");
  property p_ilaStart;
    !syncN && !cfgSyncIsDivReset ##1 syncN |=> linkState == 2'h1;
  endproperty
  a_ilaStart: assert property (p_ilaStart) else $error("no alignment after release");
  property p_ilaFirst;
    $rose(linkState == 2'h1) |-> ##2 (sym0 == S_K0 || sym0 == ~S_K0);
  endproperty
  a_ilaFirst: assert property (p_ilaFirst) else $error("alignment start marker");
  property p_ilaLen;
    $rose(linkState == 2'h2) |-> cntQ == lenQ;
  endproperty
  a_ilaLen: assert property (p_ilaLen) else $error("alignment length wrong");
  property p_ilaLast;
    $rose(linkState == 2'h2) |-> ##1 (sym0 == S_K3 || sym0 == ~S_K3);
  endproperty
  a_ilaLast: assert property (p_ilaLast) else $error("alignment end marker");
  property p_dataTake;
    $rose(linkState == 2'h2) |-> sampleTake[0];
  endproperty
  a_dataTake: assert property (p_dataTake) else $error("no sample taken at data");
  property p_regRead;
    cfgWrEn && cfgAddr == ADDR_TP_CTRL ##1 !cfgWrEn && cfgAddr == ADDR_TP_CTRL
      |=> cfgRdData == $past(cfgWrData, 2);
  endproperty
  a_regRead: assert property (p_regRead) else $error("register readback");
  property p_regOther;
    cfgAddr != ADDR_TP_CTRL |=> cfgRdData == 8'h00;
  endproperty
  a_regOther: assert property (p_regOther) else $error("unmapped read not zero");
  property p_divPulse;
    cfgSyncIsDivReset && $fell(syncN) |=> clkDivReset ##1 !clkDivReset;
  endproperty
  a_divPulse: assert property (p_divPulse) else $error("divider reset pulse");
endmodule

bind jl_tx_link jl_tx_link_chk i_jl_tx_link_chk (
  .clk(clk), .reset(reset), .syncN(syncN), .cfgSimple(cfgSimple), .cfgKMinus1(cfgKMinus1),
  .cfgSyncIsDivReset(cfgSyncIsDivReset), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
  .cfgWrEn(cfgWrEn), .cfgRdData(cfgRdData), .sampleTake(sampleTake),
  .laneSymbol(laneSymbol), .linkState(linkState), .clkDivReset(clkDivReset)
);

// ==== jl_rx_model.sv ====
/*
  jl_rx_model: receiver side; drives the sync pin from what lane 0 shows.
  Assumes the transmitter clock; the pin moves on the falling edge.
*/
`timescale 1ns/10ps
module jl_rx_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // lane 0 symbol and bench control
  input wire logic [9:0] sym,
  input wire logic holdReq,
  input wire logic [7:0] needCommas,
  // sync pin, active low
  output logic syncN
);
  logic [7:0] seenQ;
  // needCommas makes the receiver prompt or slow to lock
  always @(negedge clk or posedge reset) begin
    if (reset || holdReq) begin
      seenQ <= 8'h00;
      syncN <= 1'b0;
    end else if (!syncN) begin
      seenQ <= (sym == 10'h0FA || sym == 10'h305) ? seenQ + 8'h01 : 8'h00;
      if (seenQ >= needCommas) begin
        syncN <= 1'b1;
      end
    end
  end
endmodule

// ==== jl_tx_link_tb.sv ====
/*
  jl_tx_link_tb: self-checking bench for the transmit link layer.
  Assumes the receiver model and the bound checker; inputs move on the falling edge.
*/
`timescale 1ns/10ps
module jl_tx_link_tb;
  import jl_pkg::*;
  // simple, two lanes, K-1, scramble, lane sync, constant samples
  localparam logic [9:0] CFG_TAB [4] = '{10'h011, 10'h123, 10'h344, 10'h343};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic syncN, cfgSimple, cfgTwoLane, cfgScrambleEn, cfgLaneSyncEn, cfgSyncIsDivReset;
  logic cfgWrEn, clkDivReset, holdReq, constS;
  logic [4:0] cfgKMinus1;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData, needCommas;
  logic [LANES-1:0][13:0] laneSample = '0;
  logic [LANES-1:0] sampleTake;
  logic [LANES-1:0][9:0] laneSymbol;
  logic [1:0] linkState;
  int bad_count = 0;
  int tests_run = 0;
  jl_tx_link i_jl_tx_link (
    .clk(clk), .reset(reset), .syncN(syncN), .cfgSimple(cfgSimple), .cfgTwoLane(cfgTwoLane),
    .cfgKMinus1(cfgKMinus1), .cfgScrambleEn(cfgScrambleEn), .cfgLaneSyncEn(cfgLaneSyncEn),
    .cfgSyncIsDivReset(cfgSyncIsDivReset), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgWrEn(cfgWrEn), .cfgRdData(cfgRdData), .laneSample(laneSample),
    .sampleTake(sampleTake), .laneSymbol(laneSymbol), .linkState(linkState),
    .clkDivReset(clkDivReset)
  );
  jl_rx_model i_jl_rx_model (
    .clk(clk), .reset(reset), .sym(laneSymbol[0]), .holdReq(holdReq),
    .needCommas(needCommas), .syncN(syncN)
  );
  always #12.5 clk = ~clk;
  // constant samples make every frame repeat, so substitution is predictable
  always @(negedge clk) begin
    laneSample <= constS ? {LANES{14'h1A2B}} : 42'({$urandom(), $urandom()});
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic isK(input logic [9:0] s, input logic [9:0] v);
    return s === v || s === ~v;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(negedge clk);
    cfgWrEn = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cfgAddr = a;
    @(negedge clk);
    chk("cfgRdData", {8'h00, cfgRdData}, {8'h00, exp});
  endtask
  task automatic linkUp(input logic [9:0] c);
    int k, f, len, n, fm, am, tk, c2;
    logic [9:0] q [$];
    {cfgSimple, cfgTwoLane, cfgKMinus1, cfgScrambleEn, cfgLaneSyncEn, constS} = c;
    holdReq <= 1'b1;
    needCommas = 8'($urandom_range(2, 40));
    repeat (4) @(negedge clk);
    chk("commaState", {14'h0000, linkState}, 16'h0000);
    holdReq <= 1'b0;
    k = cfgKMinus1 + 1;
    f = cfgSimple ? 2 : 7;
    len = 4 * k * f;
    n = 0;
    while (linkState !== 2'h1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("ilaEntry", 16'(n < 400), 16'h0001);
    n = 0;
    for (int i = 0; i < len + 2; i++) begin
      q.push_back(laneSymbol[0]);
      n += (linkState == 2'h1);
      @(negedge clk);
    end
    chk("ilaLength", 16'(n), 16'(len));
    chk("ilaStart", 16'(isK(q[2], 10'h0F4)), 16'h0001);
    chk("ilaConfig", 16'(isK(q[k * f + 3], 10'h0F2)), 16'h0001);
    chk("ilaEnd", 16'(isK(q[len + 1], 10'h0F3)), 16'h0001);
    // the first data frame never substitutes, so skip one multiframe
    repeat (k * f) @(negedge clk);
    {fm, am, tk, c2} = '0;
    for (int i = 0; i < 2 * k * f; i++) begin
      fm += isK(laneSymbol[0], 10'h0F8);
      am += isK(laneSymbol[0], 10'h0F3);
      tk += sampleTake[0];
      c2 += isK(laneSymbol[2], 10'h0FA);
      @(negedge clk);
    end
    chk("takeRate", 16'(tk), 16'(2 * k * (cfgSimple ? 1 : 4)));
    chk("lane2Idle", 16'(c2), cfgTwoLane ? 16'(2 * k * f) : 16'h0000);
    if (constS && !cfgScrambleEn) begin
      chk("frameMarks", 16'(fm), 16'(cfgLaneSyncEn ? 2 * k - 2 : 2 * k));
      chk("mframeMarks", 16'(am), cfgLaneSyncEn ? 16'h0002 : 16'h0000);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // about twenty times the expected run
  initial begin
    #(25 * 20000);
    bad_count++;
    summarize();
  end
  initial begin
    logic [7:0] d, a;
    int np;
    void'($urandom(32'h5CC99E15));
    {cfgSimple, cfgTwoLane, cfgKMinus1, cfgScrambleEn, cfgLaneSyncEn, constS} = 10'h011;
    {cfgSyncIsDivReset, cfgWrEn, holdReq} = 3'b001;
    {cfgAddr, cfgWrData, needCommas} = {8'h00, 8'h00, 8'h04};
    repeat (5) @(negedge clk);
    chk("resetSymbol", {6'h00, laneSymbol[0]}, {6'h00, SYM_RESET});
    reset = 1'b0;
    rdchk(ADDR_TP_CTRL, TP_CTRL_RESET);
    chk("firstComma", {6'h00, laneSymbol[0]}, {6'h00, ~SYM_RESET});
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom());
      a = 8'($urandom_range(0, 191));
      wr(ADDR_TP_CTRL, d);
      rdchk(ADDR_TP_CTRL, d);
      wr(a, ~d);
      rdchk(a, 8'h00);
      rdchk(ADDR_TP_CTRL, d);
    end
    wr(ADDR_TP_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      linkUp(CFG_TAB[i]);
    end
    for (int c = 1; c < 6; c++) begin
      wr(ADDR_TP_CTRL, {4'h0, c[2:0], 1'b1});
      repeat (4) @(negedge clk);
      chk("patternState", {14'h0000, linkState}, 16'h0002);
      // simple packing: checker words give octets AA A8 55 54 on lane 0
      if (c == 2) begin
        np = 0;
        repeat (8) begin
          @(negedge clk);
          np += (laneSymbol[0] === 10'h15A);
        end
        chk("checkerWord", 16'(np), 16'h0002);
      end
      if (c >= 4) begin
        chk("linkPattern", 16'(isK(laneSymbol[0], c == 4 ? 10'h2AA : 10'h0FA)), 16'h0001);
      end
    end
    wr(ADDR_TP_CTRL, 8'h00);
    cfgSyncIsDivReset = 1'b1;
    holdReq <= 1'b1;
    np = 0;
    repeat (4) begin
      @(negedge clk);
      np += clkDivReset;
    end
    chk("divPulse", 16'(np), 16'h0001);
    chk("divResetKeepsLink", {14'h0000, linkState}, 16'h0002);
    summarize();
  end
endmodule
